//--- test/agclf_asserts.sv
// port assertions of the agc loop filter and gain stage
`timescale 1ns/100ps
module agclf_chk
   import agclf_pkg::*;
(
   // watched ports
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            ce,
   input wire agclf_cfg_s      cfg,
   input wire agclf_smp_s      smp_in,
   input wire agclf_out_s      smp_out,
   input wire agclf_fb_s       fb_out,
   input wire logic [LG_W-1:0] gain_word,
   input wire logic            gain_upd,
   input wire logic            loop_started
);
   localparam int WID [8] = '{4, 5, 6, 7, 8, 10, 12, 16};
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a sample taken by the stage
   sequence s_take;
      ce && smp_in.vld;
   endsequence
   // both output strobes follow taken samples; only the smp_out strobe is checked low after untaken ones
   chk_out_valid: assert property (s_take |=> smp_out.vld && fb_out.vld)
      else $error("sample lost");
   chk_out_quiet: assert property (ce && !smp_in.vld |=> !smp_out.vld)
      else $error("stray output");
   // kept bits are the top of the scaled word; residue is the rest
   chk_trunc_top: assert property (smp_out.vld && !cfg.clip_mode |->
      smp_out.i == OUT_W'(fb_out.i >>> (SC_W - WID[cfg.out_len]))) else $error("bad trunc");
   chk_clip_resid: assert property (smp_out.vld && cfg.clip_mode |->
      !fb_out.i[SC_W-1] && (fb_out.i >>> (SC_W - WID[cfg.out_len])) == 0)
      else $error("bad residue");
   // gain word: initial value, then moves only on updates
   chk_init_gain: assert property (!loop_started |->
      gain_word == cfg.initial_gain_value && !gain_upd) else $error("initial gain");
   chk_gain_hold: assert property ($changed(gain_word) && $past(loop_started) |-> gain_upd)
      else $error("gain moved");
   chk_start_kept: assert property (loop_started |=> loop_started)
      else $error("start lost");
   chk_first_upd: assert property (s_take ##0 !loop_started |=> gain_upd && loop_started)
      else $error("no first update");
   // enable low holds every registered output
   chk_ce_freeze: assert property (!ce |=> $stable(smp_out) && $stable(fb_out) &&
      $stable(gain_upd) && $stable(loop_started)) else $error("moved while frozen");
endmodule

//--- test/agclf_core_test.sv
// self-checking bench of the agc loop filter and gain stage
`timescale 1ns/100ps
module agclf_core_test;
   import agclf_pkg::*;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            snow = 1'b0;
   logic            nco = 1'b0;
   logic            ce_in = 1'b1;
   logic [3:0]      pins;
   logic [LG_W-1:0] rms = 12'h000;
   logic [LG_W-1:0] gain;
   logic            upd;
   logic            started;
   agclf_cfg_s      cfg = '{8'h10, 8'h40, 8'h00, 12'h100, 12'h000, 8'h00, 1'b0, AGCLF_W16,
                            1'b0, 2'h0, 12'h001, 16'h0004};
   agclf_smp_s      smp = '0;
   agclf_out_s      so;
   agclf_fb_s       fb;
   int              n_mismatch = 0;
   int              checks_done = 0;
   int              cyc = 0;
   int              p, d, e, kk, n, y, w, er;
   int              wid [8] = '{4, 5, 6, 7, 8, 10, 12, 16};
   int              gv [3] = '{12'h000, 12'h1a5, 12'hbff};
   // 100 mhz clock
   always #5 clk = ~clk;
   // a hung run ends as a failure
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   agclf_core i_dut (.clk(clk), .rst(rst), .ce(ce_in), .cfg(cfg), .sync_now(snow),
      .nco_start_sync(nco), .sync_pins(pins), .smp_in(smp), .rms_level(rms), .smp_out(so),
      .fb_out(fb), .gain_word(gain), .gain_upd(upd), .loop_started(started));
   agclf_rx_model i_rx (.clk(clk), .sync_pins(pins));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // three reset cycles, loop model back to its start
   // called at time zero or just after an edge, so reset spans exactly three edges
   task automatic restart();
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      y = cfg.initial_gain_value << 8;
      w = 0;
      er = 0;
   endtask
   // one sample, q carries the negated i
   task automatic send(input int x);
      @(posedge clk);
      #1 smp = '{1'b1, 16'(x), 16'(-x)};
      @(posedge clk);
      #1 smp.vld = 1'b0;
   endtask
   // coarse shift, fine multiply, 19-bit saturation
   function automatic int scale(input int x, input int g);
      longint v;
      v = (longint'(x) <<< g[11:8]) * (256 + int'(g[7:0])) >>> 8;
      return int'(v > 262143 ? 262143 : (v < -262144 ? -262144 : v));
   endfunction
   function automatic int sat(input int v);
      return v < 0 ? 0 : (v > 4095 ? 4095 : v);
   endfunction
   // edges from a sync to the update strobe, 20 if none
   task automatic sync_lat(input int src, output int lat);
      if (src < 2) begin
         @(posedge clk);
         #1 {snow, nco} = src ? 2'b01 : 2'b10;
         @(posedge clk);
         #1 {snow, nco} = 2'b00;
      end else
         i_rx.pulse(src - 2);
      lat = 0;
      while (upd !== 1'b1 && lat < 20) begin
         @(posedge clk);
         #1 lat++;
      end
   endtask
   // main sequence
   initial begin
      foreach (gv[j]) begin
         cfg.initial_gain_value = 12'(gv[j]);
         restart();
         for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            #1 cfg.out_len = agclf_wlen_e'(k);
            cfg.clip_mode = k[0];
            send(1234);
            p = scale(1234, gv[j]);
            e = scale(-1234, gv[j]);
            d = 19 - wid[k];
            chk(gain, gv[j]);
            chk(fb.i, k[0] ? p - ((p >>> d) <<< d) : p);
            chk(so.i, p >>> d);
            chk(so.q, e >>> d);
            chk(fb.q, k[0] ? e - ((e >>> d) <<< d) : e);
         end
      end
      // loop response: equal, below and above the error limit
      @(posedge clk);
      #1 cfg.desired_level = 8'h40;
      cfg.initial_gain_value = 12'h800;
      for (int r = 0; r < 3; r++) begin
         rms = r == 2 ? 12'h300 : 12'(r);
         cfg.loop_pole_location = r == 2 ? 8'h80 : 8'h00;
         // clip mode must not change the error source
         cfg.clip_mode = r == 1;
         restart();
         e = 256 - int'(rms);
         kk = (e < 0 ? -e : e) < 256 ? 16 : 64;
         repeat (6) begin
            send(100);
            y = y + w;
            w = ((int'(cfg.loop_pole_location) * w) >>> 8) + er * kk;
            er = e;
            chk(gain, sat(y >>> 8));
         end
      end
      // one update every third sample
      cfg.update_dec = 12'h003;
      restart();
      n = 0;
      repeat (7) begin
         send(5);
         n += upd;
      end
      chk(n, 3);
      // enable low: the offered sample is neither output nor counted
      @(posedge clk);
      #1 ce_in = 1'b0;
      send(5);
      chk(so.vld, 1'b0);
      ce_in = 1'b1;
      repeat (2) send(5);
      chk(upd, 1'b0);
      send(5);
      chk(upd, 1'b1);
      // sync sources; last pass pulses an unselected pin
      cfg.update_dec = 12'h000;
      restart();
      send(5);
      for (int s = 0; s < 7; s++) begin
         cfg.chan_sync_sel = s == 1;
         cfg.sync_pin_sel = 2'(s == 6 ? 0 : s - 2);
         sync_lat(s == 6 ? 3 : s, n);
         chk(n, s == 6 ? 20 : 4);
      end
      report_and_stop();
   end
endmodule
bind agclf_core agclf_chk i_chk (.clk(clk), .rst(rst), .ce(ce), .cfg(cfg), .smp_in(smp_in),
   .smp_out(smp_out), .fb_out(fb_out), .gain_word(gain_word), .gain_upd(gain_upd),
   .loop_started(loop_started));

//--- test/agclf_rx_model.sv
// downstream receiver model driving the four sync pins
`timescale 1ns/100ps
module agclf_rx_model (
   // clock in, pin syncs out
   input  wire logic  clk,
   output logic [3:0] sync_pins
);
   // pins rest low between syncs
   initial sync_pins = 4'h0;
   task automatic pulse(input int pin);
      @(posedge clk);
      #1 sync_pins[pin] = 1'b1;
      @(posedge clk);
      #1 sync_pins = 4'h0;
   endtask
endmodule

//--- verilog/agclf_core.sv
// agc loop filter, gain multiplier, truncation and sync selection
//
// Behaviour
// - second-order loop filter set by two gains, a threshold and a pole.
// - loop error is request level minus measured rms level.
// - error magnitude below threshold uses first gain, above uses second.
// - filter is K z^-2 over (1-z^-1)(1-P z^-1).
// - gains and pole are 8-bit fractions, code over 256.
// - threshold is 4 exponent bits and 8 mantissa bits.
// - linear gain is two to the power of the filter output.
// - i and q take a 4-bit coarse shift then 8-bit fine multiply.
// - initial gain value is applied until the loop first updates.
// - scaled i and q are 19 bits and feed the power measurement.
// - scaled outputs truncated to 4,5,6,7,8,10,12 or 16 bits.
// - clip mode bit set selects clipping level operation.
// - clip mode feeds back before-minus-after truncation difference.
// - clip mode compares against the same desired level register.
// - gain word follows the initial gain value until the loop starts, then changes only on aligned update events.
// - sync from channel start sync or one of four pins.
// - sync now write delivers a sync to the loop.
// - loop advances once per 1 to 4096 input samples.
// - desired level is 2 exponent and 6 mantissa bits.
// - sync loads 16-bit hold-off, acts when count reaches one.
`timescale 1ns/100ps
module agclf_core
   import agclf_pkg::*;
(
   // clock, reset, enable
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            ce,
   // control fields
   input  wire agclf_cfg_s      cfg,
   // sync sources
   input  wire logic            sync_now,
   input  wire logic            nco_start_sync,
   input  wire logic [3:0]      sync_pins,
   // sample stream in
   input  wire agclf_smp_s      smp_in,
   // measured rms level, log2 units of the gain word
   input  wire logic [LG_W-1:0] rms_level,
   // truncated outputs
   output agclf_out_s           smp_out,
   // power measurement feedback
   output agclf_fb_s            fb_out,
   // applied gain word and its update strobe
   output logic [LG_W-1:0]      gain_word,
   output logic                 gain_upd,
   output logic                 loop_started
);

   // whole module state
   typedef struct packed {
      agclf_sync_e              sync_st;
      logic [15:0]              hold_cnt;
      logic [11:0]              dec_cnt;
      logic                     started;
      logic signed [ERR_W-1:0]  err;
      logic signed [ACC_W-1:0]  w;
      logic signed [ACC_W-1:0]  y;
      logic [LG_W-1:0]          gain;
      logic                     upd;
      agclf_out_s               out;
      agclf_fb_s                fb;
   } agclf_st_s;

   agclf_st_s st_q;
   agclf_st_s st_d;

   // bits dropped below the chosen output width
   function automatic logic [4:0] drop_bits(input agclf_wlen_e wl);
      unique case (wl)
         AGCLF_W4:  drop_bits = 5'(SC_W - 4);
         AGCLF_W5:  drop_bits = 5'(SC_W - 5);
         AGCLF_W6:  drop_bits = 5'(SC_W - 6);
         AGCLF_W7:  drop_bits = 5'(SC_W - 7);
         AGCLF_W8:  drop_bits = 5'(SC_W - 8);
         AGCLF_W10: drop_bits = 5'(SC_W - 10);
         AGCLF_W12: drop_bits = 5'(SC_W - 12);
         AGCLF_W16: drop_bits = 5'(SC_W - 16);
      endcase
   endfunction

   // coarse shift, fine multiply and saturation to the scaled width
   function automatic logic signed [SC_W-1:0] scale(
      input logic signed [IN_W-1:0] x,
      input logic [LG_W-1:0]        g
   );
      logic signed [IN_W+15:0]        sh;
      logic signed [IN_W+15+MANT_W+1:0] pr;
      logic signed [IN_W+15+MANT_W+1:0] lim;
      sh  = (IN_W+16)'(x) <<< g[LG_W-1 -: EXP_W];
      pr  = (IN_W+MANT_W+17)'(sh) * $signed({1'b0, 1'b1, g[MANT_W-1:0]});
      lim = pr >>> MANT_W;
      if (lim > $signed((IN_W+MANT_W+17)'({1'b0, {(SC_W-1){1'b1}}}))) begin
         scale = {1'b0, {(SC_W-1){1'b1}}};
      end else if (lim < -$signed((IN_W+MANT_W+17)'({1'b1, {(SC_W-1){1'b0}}}))) begin
         scale = {1'b1, {(SC_W-1){1'b0}}};
      end else begin
         scale = lim[SC_W-1:0];
      end
   endfunction

   // fixed-point product of a signed value and an 8-bit fraction, kept at acc width
   function automatic logic signed [ACC_W-1:0] frac_mul(
      input logic signed [ACC_W-1:0] v,
      input logic [7:0]              k
   );
      logic signed [ACC_W+8:0] p;
      p = (ACC_W+9)'(v) * $signed({1'b0, k});
      frac_mul = p[ACC_W+7:8];
   endfunction

   // selected sync and update strobes
   logic                    sync_in;
   logic                    sync_fire;
   logic                    smp_tick;
   logic                    upd_evt;
   logic [LG_W-1:0]         req_lvl;
   logic signed [ERR_W-1:0] err_now;
   logic [ERR_W-1:0]        err_mag;
   logic [7:0]              k_sel;
   logic signed [ACC_W-1:0] y_nxt;
   logic [LG_W-1:0]         applied;
   logic signed [SC_W-1:0]  sc_i;
   logic signed [SC_W-1:0]  sc_q;
   logic signed [SC_W-1:0]  tr_i;
   logic signed [SC_W-1:0]  tr_q;
   logic [4:0]              drop;

   // sync source choice
   always_comb begin
      if (cfg.chan_sync_sel) begin
         sync_in = nco_start_sync;
      end else begin
         sync_in = sync_pins[cfg.sync_pin_sel];
      end
      sync_in = sync_in | sync_now;
   end

   // act when hold-off count hits one
   assign sync_fire = (st_q.sync_st == AGCLF_HOLD) && (st_q.hold_cnt <= 16'h0001);

   assign smp_tick = smp_in.vld && (st_q.dec_cnt == 12'h000);
   // updates only at tick or aligned sync
   assign upd_evt  = smp_tick || sync_fire;

   // desired level widened into gain-word units
   assign req_lvl = {{(EXP_W-DES_EXP_W){1'b0}},
                     cfg.desired_level[DES_EXP_W+DES_MAN_W-1 -: DES_EXP_W],
                     cfg.desired_level[DES_MAN_W-1:0], {DES_MAN_SH{1'b0}}};

   // error and gain choice
   always_comb begin
      // request minus measured level; same register in clip mode
      err_now = $signed({2'b00, req_lvl}) - $signed({2'b00, rms_level});
      err_mag = err_now[ERR_W-1] ? ERR_W'(-err_now) : ERR_W'(err_now);
      // threshold held as 4.8 floating word
      if (err_mag < {2'b00, cfg.loop_error_limit}) begin
         k_sel = cfg.loop_gain_first;
      end else begin
         k_sel = cfg.loop_gain_second;
      end
   end

   // initial gain until the loop starts
   assign applied = st_q.started ? st_q.gain : cfg.initial_gain_value;

   // gain multiply and truncation
   always_comb begin
      // gain word is log2, shift then fraction
      sc_i = scale(smp_in.i, applied);
      sc_q = scale(smp_in.q, applied);
      // keep the top bits of the scaled word
      drop = drop_bits(cfg.out_len);
      tr_i = (sc_i >>> drop) <<< drop;
      tr_q = (sc_q >>> drop) <<< drop;
   end

   // next-state logic
   always_comb begin
      st_d     = st_q;
      st_d.upd = 1'b0;
      y_nxt    = st_q.y;

      unique case (st_q.sync_st)
         AGCLF_IDLE: begin
            if (sync_in) begin
               st_d.sync_st  = AGCLF_HOLD;
               st_d.hold_cnt = cfg.holdoff;
            end
         end
         AGCLF_HOLD: begin
            if (sync_fire) begin
               st_d.sync_st = AGCLF_IDLE;
            end else begin
               st_d.hold_cnt = st_q.hold_cnt - 16'h0001;
            end
         end
      endcase

      // count input samples, reload on update or sync
      if (sync_fire || smp_tick) begin
         st_d.dec_cnt = cfg.update_dec - 12'h001;
      end else if (smp_in.vld) begin
         st_d.dec_cnt = st_q.dec_cnt - 12'h001;
      end

      // before the first update the filter tracks the initial gain
      if (!st_q.started) begin
         st_d.y = ACC_W'({cfg.initial_gain_value, {FRAC_W{1'b0}}});
         st_d.w = '0;
         y_nxt  = st_d.y;
      end

      // w is the pole stage, y the integrator
      // gain and pole as code over 256
      if (upd_evt) begin
         st_d.err     = err_now;
         st_d.w       = frac_mul(st_q.w, cfg.loop_pole_location) +
                        ACC_W'(ACC_W'(st_q.err) * ACC_W'(k_sel));
         y_nxt        = (st_q.started ? st_q.y : st_d.y) + st_q.w;
         st_d.y       = y_nxt;
         st_d.started = 1'b1;
         st_d.upd     = 1'b1;
         // saturate to the 0 to 96.3 db range
         if (y_nxt < 0) begin
            st_d.gain = '0;
         end else if (y_nxt > $signed(ACC_W'({GAIN_MAX, {FRAC_W{1'b0}}}))) begin
            st_d.gain = GAIN_MAX;
         end else begin
            st_d.gain = y_nxt[LG_W+FRAC_W-1:FRAC_W];
         end
      end

      // output holds the retained bits only
      st_d.out.vld = smp_in.vld;
      if (smp_in.vld) begin
         st_d.out.i = OUT_W'(sc_i >>> drop);
         st_d.out.q = OUT_W'(sc_q >>> drop);
      end

      // scaled words go back to power measurement
      // mode bit picks the feedback path
      st_d.fb.vld = smp_in.vld;
      if (smp_in.vld) begin
         if (cfg.clip_mode) begin
            st_d.fb.i = sc_i - tr_i;
            st_d.fb.q = sc_q - tr_q;
         end else begin
            st_d.fb.i = sc_i;
            st_d.fb.q = sc_q;
         end
      end
   end

   // state register; enable low freezes everything
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '{sync_st: AGCLF_IDLE, dec_cnt: 12'h000, default: '0};
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // outputs from the state; gain word through the initial gain mux
   assign smp_out      = st_q.out;
   assign fb_out       = st_q.fb;
   assign gain_word    = applied;
   assign gain_upd     = st_q.upd;
   assign loop_started = st_q.started;

endmodule

//--- verilog/agclf_pkg.sv
// shared types and constants of the agc loop filter and gain stage
package agclf_pkg;

   // data widths
   localparam int IN_W   = 16;
   localparam int SC_W   = 19;
   localparam int OUT_W  = 16;
   localparam int LG_W   = 12;
   localparam int ERR_W  = 14;
   localparam int ACC_W  = 24;
   localparam int FRAC_W = 8;
   localparam int MANT_W = 8;
   localparam int EXP_W  = 4;

   // reset values of the programmable fields
   localparam logic [7:0]  RST_GAIN_BELOW = 8'h10;
   localparam logic [7:0]  RST_GAIN_ABOVE = 8'h40;
   localparam logic [7:0]  RST_POLE       = 8'h00;
   localparam logic [11:0] RST_LIMIT      = 12'h100;
   localparam logic [11:0] RST_INIT_GAIN  = 12'h000;
   localparam logic [7:0]  RST_DESIRED    = 8'h00;
   localparam logic [11:0] RST_UPD_DEC    = 12'h001;
   localparam logic [15:0] RST_HOLDOFF    = 16'h0001;

   // largest gain word, 0 to 96.3 db
   localparam logic [LG_W-1:0] GAIN_MAX = 12'hfff;

   // desired level: 2 exponent, 6 mantissa bits; mantissa step is 4 gain lsbs
   localparam int DES_EXP_W = 2;
   localparam int DES_MAN_W = 6;
   localparam int DES_MAN_SH = 2;

   // output word length codes
   typedef enum logic [2:0] {
      AGCLF_W4, AGCLF_W5, AGCLF_W6, AGCLF_W7,
      AGCLF_W8, AGCLF_W10, AGCLF_W12, AGCLF_W16
   } agclf_wlen_e;

   // sync hold-off sequencer
   typedef enum logic {AGCLF_IDLE, AGCLF_HOLD} agclf_sync_e;

   // programmable control fields
   typedef struct packed {
      logic [7:0]  loop_gain_first;
      logic [7:0]  loop_gain_second;
      logic [7:0]  loop_pole_location;
      logic [11:0] loop_error_limit;
      logic [11:0] initial_gain_value;
      logic [7:0]  desired_level;
      logic        clip_mode;
      agclf_wlen_e out_len;
      logic        chan_sync_sel;
      logic [1:0]  sync_pin_sel;
      logic [11:0] update_dec;
      logic [15:0] holdoff;
   } agclf_cfg_s;

   // complex sample in
   typedef struct packed {
      logic                   vld;
      logic signed [IN_W-1:0] i;
      logic signed [IN_W-1:0] q;
   } agclf_smp_s;

   // truncated output sample
   typedef struct packed {
      logic                    vld;
      logic signed [OUT_W-1:0] i;
      logic signed [OUT_W-1:0] q;
   } agclf_out_s;

   // samples fed back to the power measurement
   typedef struct packed {
      logic                   vld;
      logic signed [SC_W-1:0] i;
      logic signed [SC_W-1:0] q;
   } agclf_fb_s;

endpackage
